// ### rtl/adcosc_regs.sv
// converter result, oversampling control and common control registers
// Contract
// - the latest routine result sits read-only in bits 15:0 of the result register, upper bits zero.
// - with per-trigger mode clear, all oversampled conversions run back to back after one trigger.
// - with per-trigger mode set, each oversampled conversion waits for its own trigger.
// - the oversampled sum is shifted right by 0 to 8 bits per the shift field.
// - the ratio field selects 2x at code 0 doubling up to 256x at code 7.
// - oversampling is applied only while the enable bit is set.
// - bit 23 of the common control register enables internal channels 9 and 10.
// - the clock field selects bus clock divided by 2, 4, 6, 8 or 5, 6, 10, 20.
`timescale 1ns/1ps
`default_nettype none
module adcosc_regs
  import adcosc_pkg::*;
(
  // clock and reset
  input  wire logic                     ref_clk_i,
  input  wire logic                     rst_n_i,
  // register port
  input  wire logic [11:0]              reg_addr_i,
  input  wire logic [31:0]              reg_wdata_i,
  input  wire logic                     reg_we_i,
  input  wire logic                     reg_re_i,
  output logic      [31:0]              reg_rdata_o,
  // conversion core and triggers
  input  wire logic                     converter_on_i,
  input  wire logic                     trigger_i,
  input  wire adcosc_sample_t           sample_i,
  output logic                          conv_start_o,
  output logic                          result_valid_o,
  // control outputs
  output logic                          internal_channels_enable_o,
  output logic                          converter_clock_o
);

  typedef enum logic [1:0] {
    ADCOSC_IDLE,
    ADCOSC_BUSY,
    ADCOSC_ARMED
  } adcosc_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  adcosc_ovs_cfg_t ovs_d, ovs_q;
  adcosc_cctl_t    cctl_d, cctl_q;
  logic [31:0]     rdata_d, rdata_q;
  logic [ADCOSC_DATA_W-1:0] result_d, result_q;
  logic                     ovs_wr, cctl_wr;

  assign ovs_wr  = reg_we_i && (reg_addr_i == ADCOSC_OFS_OVSCTL);
  assign cctl_wr = reg_we_i && (reg_addr_i == ADCOSC_OFS_CCTL);

  always_comb begin
    ovs_d   = ovs_q;
    cctl_d  = cctl_q;
    // zero outside a read so a stale word never looks fresh
    rdata_d = '0;
    if (ovs_wr) begin
      // field stability while converting is left to software
      ovs_d.per_trigger_oversample = reg_wdata_i[ADCOSC_OVS_TRIG_BIT];
      ovs_d.oversample_shift       = reg_wdata_i[ADCOSC_OVS_SHIFT_LSB +: 4];
      ovs_d.oversample_ratio       = reg_wdata_i[ADCOSC_OVS_RATIO_LSB +: 3];
      ovs_d.oversample_enable      = reg_wdata_i[ADCOSC_OVS_EN_BIT];
    end
    if (cctl_wr) begin
      cctl_d.internal_channels_enable = reg_wdata_i[ADCOSC_INT_CHAN_BIT];
      cctl_d.converter_clock_select   = reg_wdata_i[ADCOSC_CLK_SEL_LSB +: 3];
    end
    if (reg_re_i) begin
      unique case (reg_addr_i)
        ADCOSC_OFS_RESULT: rdata_d = {16'h0000, result_q};
        ADCOSC_OFS_OVSCTL: begin
          rdata_d[ADCOSC_OVS_TRIG_BIT]          = ovs_q.per_trigger_oversample;
          rdata_d[ADCOSC_OVS_SHIFT_LSB +: 4]    = ovs_q.oversample_shift;
          rdata_d[ADCOSC_OVS_RATIO_LSB +: 3]    = ovs_q.oversample_ratio;
          rdata_d[ADCOSC_OVS_EN_BIT]            = ovs_q.oversample_enable;
        end
        ADCOSC_OFS_CCTL: begin
          rdata_d[ADCOSC_INT_CHAN_BIT]          = cctl_q.internal_channels_enable;
          rdata_d[ADCOSC_CLK_SEL_LSB +: 3]      = cctl_q.converter_clock_select;
        end
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ovs_q   <= '{per_trigger_oversample: ADCOSC_RST_OVSCTL[ADCOSC_OVS_TRIG_BIT],
                   oversample_shift:       ADCOSC_RST_OVSCTL[ADCOSC_OVS_SHIFT_LSB +: 4],
                   oversample_ratio:       ADCOSC_RST_OVSCTL[ADCOSC_OVS_RATIO_LSB +: 3],
                   oversample_enable:      ADCOSC_RST_OVSCTL[ADCOSC_OVS_EN_BIT]};
      cctl_q  <= '{internal_channels_enable: ADCOSC_RST_CCTL[ADCOSC_INT_CHAN_BIT],
                   converter_clock_select:   ADCOSC_RST_CCTL[ADCOSC_CLK_SEL_LSB +: 3]};
      rdata_q <= '0;
    end else begin
      ovs_q   <= ovs_d;
      cctl_q  <= cctl_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o                = rdata_q;
  // channel enable leaves straight from its register bit
  assign internal_channels_enable_o = cctl_q.internal_channels_enable;

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencing and oversampling

  adcosc_state_t            state_d, state_q;
  logic [ADCOSC_ACC_W-1:0]  acc_d, acc_q;
  logic [ADCOSC_CNT_W-1:0]  cnt_d, cnt_q;
  logic                     start_d, start_q;
  logic                     valid_d, valid_q;
  logic [ADCOSC_CNT_W-1:0]  ratio_n;
  logic [3:0]               shift_n;
  logic [ADCOSC_ACC_W-1:0]  sum;
  logic [ADCOSC_ACC_W-1:0]  shifted;
  logic                     last_smp;

  always_comb begin
    // ratio code n gives 2 << n samples
    ratio_n = 9'h002 << ovs_q.oversample_ratio;
    // reserved shift codes behave as the largest legal shift
    shift_n = (ovs_q.oversample_shift > ADCOSC_SHIFT_MAX) ? ADCOSC_SHIFT_MAX
                                                           : ovs_q.oversample_shift;
    // 24 bits hold 256 full-scale samples without wrapping
    sum      = acc_q + {8'h00, sample_i.data};
    shifted  = sum >> shift_n;
    last_smp = (cnt_q == ratio_n - 9'h001);
  end

  always_comb begin
    state_d  = state_q;
    acc_d    = acc_q;
    cnt_d    = cnt_q;
    start_d  = 1'b0;
    valid_d  = 1'b0;
    result_d = result_q;
    unique case (state_q)
      ADCOSC_IDLE: begin
        if (trigger_i && converter_on_i) begin
          acc_d   = '0;
          cnt_d   = '0;
          start_d = 1'b1;
          state_d = ADCOSC_BUSY;
        end
      end
      ADCOSC_BUSY: begin
        // an abort drops the partial sum and gives no result
        if (!converter_on_i) begin
          state_d = ADCOSC_IDLE;
        end else if (sample_i.valid) begin
          if (!ovs_q.oversample_enable) begin
            result_d = sample_i.data;
            valid_d  = 1'b1;
            state_d  = ADCOSC_IDLE;
          end else if (last_smp) begin
            result_d = shifted[ADCOSC_DATA_W-1:0];
            valid_d  = 1'b1;
            state_d  = ADCOSC_IDLE;
          end else begin
            acc_d = sum;
            cnt_d = cnt_q + 9'h001;
            // per-trigger runs park until the next trigger
            if (ovs_q.per_trigger_oversample) begin
              state_d = ADCOSC_ARMED;
            end else begin
              start_d = 1'b1;
            end
          end
        end
      end
      ADCOSC_ARMED: begin
        // triggers seen while busy were dropped, not queued
        if (!converter_on_i) begin
          state_d = ADCOSC_IDLE;
        end else if (trigger_i) begin
          start_d = 1'b1;
          state_d = ADCOSC_BUSY;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state_q  <= ADCOSC_IDLE;
      acc_q    <= '0;
      cnt_q    <= '0;
      start_q  <= 1'b0;
      valid_q  <= 1'b0;
      result_q <= ADCOSC_RST_RESULT[ADCOSC_DATA_W-1:0];
    end else begin
      state_q  <= state_d;
      acc_q    <= acc_d;
      cnt_q    <= cnt_d;
      start_q  <= start_d;
      valid_q  <= valid_d;
      result_q <= result_d;
    end
  end

  assign conv_start_o   = start_q;
  assign result_valid_o = valid_q;

  ////////////////////////////////////////////////////////////////////////////
  // converter clock

  // divider sees a new select only once the register write lands
  adcosc_clk_div u_clk_div (
    .ref_clk_i                (ref_clk_i),
    .rst_n_i                  (rst_n_i),
    .converter_clock_select_i (cctl_q.converter_clock_select),
    .converter_clock_o        (converter_clock_o)
  );

endmodule
`default_nettype wire

// ### pkg/adcosc_pkg.sv
// shared constants and types of the converter oversampling and clock register block
package adcosc_pkg;

  // register byte offsets
  localparam logic [11:0] ADCOSC_OFS_RESULT = 12'h04C;
  localparam logic [11:0] ADCOSC_OFS_OVSCTL = 12'h080;
  localparam logic [11:0] ADCOSC_OFS_CCTL   = 12'h304;

  // reset values
  localparam logic [31:0] ADCOSC_RST_RESULT = 32'h00000000;
  localparam logic [31:0] ADCOSC_RST_OVSCTL = 32'h00000000;
  localparam logic [31:0] ADCOSC_RST_CCTL   = 32'h00000000;

  // oversampling control fields
  localparam int ADCOSC_OVS_EN_BIT    = 0;
  localparam int ADCOSC_OVS_RATIO_LSB = 2;
  localparam int ADCOSC_OVS_SHIFT_LSB = 5;
  localparam int ADCOSC_OVS_TRIG_BIT  = 9;
  localparam logic [3:0] ADCOSC_SHIFT_MAX = 4'h8;

  // common control fields
  localparam int ADCOSC_CLK_SEL_LSB  = 16;
  localparam int ADCOSC_INT_CHAN_BIT = 23;

  // widths
  localparam int ADCOSC_DATA_W = 16;
  localparam int ADCOSC_ACC_W  = 24;
  localparam int ADCOSC_CNT_W  = 9;
  localparam int ADCOSC_DIV_W  = 5;

  // converter clock divide ratio per select code
  localparam logic [ADCOSC_DIV_W-1:0] ADCOSC_DIV_RATIO [8] = '{
    5'h02, 5'h04, 5'h06, 5'h08, 5'h05, 5'h06, 5'h0A, 5'h14
  };

  typedef struct packed {
    logic                     valid;
    logic [ADCOSC_DATA_W-1:0] data;
  } adcosc_sample_t;

  typedef struct packed {
    logic       per_trigger_oversample;
    logic [3:0] oversample_shift;
    logic [2:0] oversample_ratio;
    logic       oversample_enable;
  } adcosc_ovs_cfg_t;

  typedef struct packed {
    logic       internal_channels_enable;
    logic [2:0] converter_clock_select;
  } adcosc_cctl_t;

endpackage

// ### rtl/adcosc_clk_div.sv
// converter clock divider with selectable divide ratio
`timescale 1ns/1ps
`default_nettype none
module adcosc_clk_div
  import adcosc_pkg::*;
(
  // clock and reset
  input  wire logic                    ref_clk_i,
  input  wire logic                    rst_n_i,
  // control
  input  wire logic [2:0]              converter_clock_select_i,
  // divided clock
  output logic                         converter_clock_o
);

  logic [ADCOSC_DIV_W-1:0] div_ratio;
  logic [ADCOSC_DIV_W-1:0] cnt_d, cnt_q;
  logic                    clk_d, clk_q;

  // both bus clocks are ref_clk_i inside this block
  always_comb begin
    div_ratio = ADCOSC_DIV_RATIO[converter_clock_select_i];
  end

  always_comb begin
    // a shrinking ratio restarts the period instead of running past it
    if (cnt_q >= div_ratio - 5'h01) begin
      cnt_d = '0;
    end else begin
      cnt_d = cnt_q + 5'h01;
    end
    // odd ratios give a duty half a cycle short of half
    clk_d = (cnt_d < (div_ratio >> 1));
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
      clk_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      clk_q <= clk_d;
    end
  end

  assign converter_clock_o = clk_q;

endmodule
`default_nettype wire

// ### tb/adcosc_chk.sv
// concurrent checks on the converter register block ports
`timescale 1ns/1ps
`default_nettype none
module adcosc_chk
  import adcosc_pkg::*;
(
  // watched ports
  input wire logic           ref_clk_i,
  input wire logic           rst_n_i,
  input wire logic [11:0]    reg_addr_i,
  input wire logic [31:0]    reg_wdata_i,
  input wire logic           reg_we_i,
  input wire logic           reg_re_i,
  input wire logic [31:0]    reg_rdata_o,
  input wire logic           converter_on_i,
  input wire adcosc_sample_t sample_i,
  input wire logic           conv_start_o,
  input wire logic           result_valid_o,
  input wire logic           internal_channels_enable_o,
  input wire logic           converter_clock_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_rd(a);
    reg_re_i && reg_addr_i == a;
  endsequence
  ////////////////////////////////////////////////////////////////
  a_rd_idle: assert property (!reg_re_i |=> reg_rdata_o == 32'h0)
    else $error("read data not zero outside a read");
  a_res_rsvd: assert property (s_rd(ADCOSC_OFS_RESULT) |=> reg_rdata_o[31:16] == 16'h0)
    else $error("result upper bits not zero");
  a_ovs_rsvd: assert property (s_rd(ADCOSC_OFS_OVSCTL) |=> {reg_rdata_o[31:10], reg_rdata_o[1]} == 23'h0)
    else $error("oversampling reserved bits not zero");
  a_cctl_rd: assert property (s_rd(ADCOSC_OFS_CCTL) |=> reg_rdata_o[23] == internal_channels_enable_o)
    else $error("channel enable bit differs from output");
  a_chan_wr: assert property (reg_we_i && reg_addr_i == ADCOSC_OFS_CCTL
    |=> internal_channels_enable_o == $past(reg_wdata_i[23]))
    else $error("channel enable did not follow write");
  a_start_on: assert property (conv_start_o |-> $past(converter_on_i))
    else $error("start issued with converter off");
  a_res_cause: assert property (result_valid_o |-> $past(sample_i.valid) && !$past(result_valid_o))
    else $error("result not one cycle after a sample");
  a_clk_high: assert property ($rose(converter_clock_o) |-> ##[1:10] !converter_clock_o)
    else $error("converter clock high too long");
  a_clk_low: assert property ($fell(converter_clock_o) |-> ##[1:10] converter_clock_o)
    else $error("converter clock low too long");
endmodule
`default_nettype wire

// ### tb/adcosc_core_model.sv
// behavioural conversion core answering each start with one sample
`timescale 1ns/1ps
`default_nettype none
module adcosc_core_model
  import adcosc_pkg::*;
(
  // clock and reset
  input  wire logic           ref_clk_i,
  input  wire logic           rst_n_i,
  // start request and sample answer
  input  wire logic           conv_start_i,
  input  wire logic           slow_i,
  input  wire logic [15:0]    rnd_i,
  output var  adcosc_sample_t sample_o
);
  int cnt;
  initial sample_o = '0;
  always @(posedge ref_clk_i) begin
    sample_o.valid <= 1'b0;
    // data keeps changing outside the valid cycle so stale values never match
    sample_o.data <= ~sample_o.data;
    if (!rst_n_i) begin
      cnt = 0;
    end else if (conv_start_i) begin
      cnt = slow_i ? 4 : 1;
    end else if (cnt > 0) begin
      cnt = cnt - 1;
      if (cnt == 0) begin
        sample_o <= '{valid: 1'b1, data: rnd_i};
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/tb_adcosc_regs.sv
// self-checking bench for the converter register block
`timescale 1ns/1ps
`default_nettype none
module tb_adcosc_regs
  import adcosc_pkg::*;
;
  logic ref_clk_i = 1'b0, rst_n_i = 1'b0, reg_we_i = 1'b0, reg_re_i = 1'b0;
  logic converter_on_i = 1'b0, trigger_i = 1'b0, slow = 1'b0, rd_pend = 1'b0;
  logic conv_start_o, result_valid_o, internal_channels_enable_o, converter_clock_o, got_res;
  logic [11:0] reg_addr_i = 12'h000;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
  logic [15:0] rnd = 16'h0;
  logic [23:0] acc;
  logic [15:0] last_s = 16'h0000;
  logic [31:0] rq[$];
  adcosc_sample_t sample_i;
  integer seed = 32'h477B;
  int errors = 0, check_count = 0, starts, nsmp, t;
  int divs[8] = '{2, 4, 6, 8, 5, 6, 10, 20};
  time t0;
  always #2 ref_clk_i = ~ref_clk_i;
  adcosc_regs i_dut (.ref_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i,
    .reg_rdata_o, .converter_on_i, .trigger_i, .sample_i, .conv_start_o, .result_valid_o,
    .internal_channels_enable_o, .converter_clock_o);
  adcosc_core_model i_core (.ref_clk_i, .rst_n_i, .conv_start_i(conv_start_o), .slow_i(slow),
    .rnd_i(rnd), .sample_o(sample_i));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_we_i <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    rq.push_back(e);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_re_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_re_i <= 1'b0;
  endtask
  // outputs are read mid-cycle, away from the edges that move them
  always @(posedge ref_clk_i) begin
    rd_pend <= reg_re_i;
    rnd <= 16'($random(seed));
  end
  always @(negedge ref_clk_i) begin
    if (rd_pend) chk("rdata", rq.pop_front(), reg_rdata_o);
    if (conv_start_o) starts++;
    if (sample_i.valid) begin
      acc += 24'(sample_i.data);
      nsmp++;
    end
    if (result_valid_o) got_res = 1'b1;
  end
  task automatic conv(input logic [31:0] cfg, input int n);
    logic [23:0] s;
    wr(ADCOSC_OFS_OVSCTL, cfg);
    acc = 24'h0;
    nsmp = 0;
    starts = 0;
    got_res = 1'b0;
    slow <= cfg[3];
    converter_on_i <= 1'b1;
    for (int k = 0; k < n; k++) begin
      if (k == 0 || cfg[9]) begin
        @(posedge ref_clk_i) trigger_i <= 1'b1;
        @(posedge ref_clk_i) trigger_i <= 1'b0;
      end
      for (t = 0; t < 50 && nsmp <= k; t++) @(posedge ref_clk_i);
      if (cfg[9]) begin
        repeat (4) @(posedge ref_clk_i);
        chk("trig starts", 32'(k + 1), 32'(starts));
      end
    end
    for (t = 0; t < 50 && !got_res; t++) @(posedge ref_clk_i);
    chk("result seen", 32'h1, {31'h0, got_res});
    chk("starts", 32'(n), 32'(starts));
    // reserved shift codes act as the largest shift
    s = cfg[0] ? acc >> ((cfg[8:5] > ADCOSC_SHIFT_MAX) ? ADCOSC_SHIFT_MAX : cfg[8:5]) : acc;
    last_s = s[15:0];
    rd(ADCOSC_OFS_RESULT, {16'h0, s[15:0]});
    converter_on_i <= 1'b0;
    $display("test conv %h done", cfg);
  endtask
  // converter switched off mid-run: no result, result register keeps its value
  task automatic abort_conv;
    wr(ADCOSC_OFS_OVSCTL, 32'h00000001);
    nsmp = 0;
    got_res = 1'b0;
    converter_on_i <= 1'b1;
    @(posedge ref_clk_i) trigger_i <= 1'b1;
    @(posedge ref_clk_i) trigger_i <= 1'b0;
    for (t = 0; t < 50 && nsmp == 0; t++) @(posedge ref_clk_i);
    chk("abort first sample", 32'h1, 32'(nsmp));
    converter_on_i <= 1'b0;
    repeat (20) @(posedge ref_clk_i);
    chk("abort result", 32'h0, {31'h0, got_res});
    rd(ADCOSC_OFS_RESULT, {16'h0, last_s});
    $display("test abort done");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge ref_clk_i);
    errors++;
    complete_run;
  end
  initial begin
    repeat (3) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    rd(ADCOSC_OFS_RESULT, 32'h0);
    rd(ADCOSC_OFS_OVSCTL, 32'h0);
    rd(ADCOSC_OFS_CCTL, 32'h0);
    rd(12'h100, 32'h0);
    wr(ADCOSC_OFS_OVSCTL, 32'hFFFFFFFF);
    rd(ADCOSC_OFS_OVSCTL, 32'h000003FD);
    wr(ADCOSC_OFS_RESULT, 32'hFFFFFFFF);
    wr(12'h100, 32'hFFFFFFFF);
    rd(ADCOSC_OFS_RESULT, 32'h0);
    $display("test regs done");
    for (int r = 0; r < 8; r++) conv({22'h0, r[0], 4'(r + 1), r[2:0], 2'b01}, 2 << r);
    conv(32'h000000E0, 1);
    conv(32'h000001E1, 2);
    abort_conv;
    for (int c = 0; c < 8; c++) begin
      wr(ADCOSC_OFS_CCTL, {8'h0, c[0], 4'h0, c[2:0], 16'h0});
      rd(ADCOSC_OFS_CCTL, {8'h0, c[0], 4'h0, c[2:0], 16'h0});
      chk("chan en", {31'h0, c[0]}, {31'h0, internal_channels_enable_o});
      for (int i = 0; i < 3; i++) begin
        for (t = 0; t < 50 && converter_clock_o; t++) @(posedge ref_clk_i);
        for (t = 0; t < 50 && !converter_clock_o; t++) @(posedge ref_clk_i);
        if (i == 1) t0 = $time;
      end
      chk("clock div", 32'(divs[c]), 32'(($time - t0) / 4));
    end
    $display("test clock done");
    complete_run;
  end
endmodule
bind adcosc_regs adcosc_chk i_chk (.ref_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_we_i,
  .reg_re_i, .reg_rdata_o, .converter_on_i, .sample_i, .conv_start_o, .result_valid_o,
  .internal_channels_enable_o, .converter_clock_o);
`default_nettype wire
